// ### cpu_decode_pkg.sv
// Package: register map, opcode table, cycle counts and flag marking
package cpu_decode_pkg;

  // ****************************************
  // Register map (byte addresses, one word each)
  // ****************************************
  localparam int ADR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INSTR = 8'h04;
  localparam logic [7:0] REG_OPERAND = 8'h08;
  localparam logic [7:0] REG_FLAGS = 8'h0C;
  localparam logic [7:0] REG_RESULT = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_SP = 8'h18;
  localparam logic [7:0] REG_PC = 8'h1C;

  // Field positions
  localparam int CTRL_START = 0;
  localparam int FLAGS_LSB = 2;
  localparam int STATUS_BUSY = 0;
  localparam int STATUS_ILLEGAL = 1;
  localparam int STATUS_FETCH_LSB = 2;
  localparam int STATUS_EXEC_LSB = 6;
  localparam int BIT_P_POS = 7;
  localparam int BIT_SEL_LSB = 4;

  // Flag indices inside the 6-bit flag word
  localparam int FLAG_C = 5;
  localparam int FLAG_Z = 4;
  localparam int FLAG_S = 3;
  localparam int FLAG_V = 2;
  localparam int FLAG_D = 1;
  localparam int FLAG_H = 0;
  localparam int NUM_FLAGS = 6;

  // Reset values
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] CALL_SP_STEP = 16'h0002;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_PREFIX = 8'h1F;
  localparam logic [3:0] HI_ADD = 4'h0;
  localparam logic [3:0] HI_ADD_CARRY = 4'h1;
  localparam logic [3:0] HI_AND = 4'h5;
  localparam logic [3:0] HI_COMPARE = 4'hA;
  localparam logic [3:0] LO_FIRST = 4'h2;
  localparam logic [3:0] LO_SPLIT = 4'h4;
  localparam logic [3:0] LO_LAST = 4'h7;
  localparam logic [3:0] LO_EXT = 4'h8;
  localparam logic [3:0] LO_EXT_IMM = 4'h9;
  localparam logic [7:0] OP_ATOMIC = 8'h2F;
  localparam logic [7:0] OP_BIT_WRITE = 8'hE2;
  localparam logic [7:0] OP_BIT_REVERSE = 8'hD5;
  localparam logic [7:0] OP_BIT_BRANCH = 8'hF6;
  localparam logic [7:0] OP_BIT_BRANCH_IND = 8'hF7;
  localparam logic [7:0] OP_CALL_PAIR = 8'hD4;
  localparam logic [7:0] OP_CALL_DIRECT = 8'hD6;
  localparam logic [7:0] OP_CARRY_FLIP = 8'hEF;
  localparam logic [7:0] OP_CLEAR = 8'hB0;
  localparam logic [7:0] OP_CLEAR_IND = 8'hB1;
  localparam logic [7:0] OP_COMPLEMENT = 8'h60;
  localparam logic [7:0] OP_COMPLEMENT_IND = 8'h61;

  // Cycle counts in CPU clocks
  localparam logic [3:0] CYC_1 = 4'h1;
  localparam logic [3:0] CYC_2 = 4'h2;
  localparam logic [3:0] CYC_3 = 4'h3;
  localparam logic [3:0] CYC_4 = 4'h4;
  localparam logic [3:0] CYC_6 = 4'h6;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    K_NONE, K_ADD_CARRY, K_ADD, K_AND, K_COMPARE, K_COMPARE_CARRY,
    K_ATOMIC, K_BIT_WRITE, K_BIT_REVERSE, K_BIT_BRANCH, K_CALL,
    K_CARRY_FLIP, K_CLEAR, K_COMPLEMENT
  } kind_t;

  typedef enum logic [1:0] {MK_RESULT, MK_ZERO, MK_KEEP, MK_UNDEF} mark_t;

  typedef struct packed {
    logic valid;
    kind_t kind;
    logic [3:0] fetch;
    logic [3:0] exec;
  } dec_t;

  // Decode one or two opcode bytes into kind and cycle counts
  function automatic dec_t decode(input logic [7:0] b0,
                                  input logic [7:0] b1);
    dec_t d;
    logic pre;
    logic [7:0] op;
    d = '0;
    pre = (b0 == OP_PREFIX);
    op = pre ? b1 : b0;
    if (op[3:0] >= LO_FIRST && op[3:0] <= LO_LAST &&
        (op[7:4] == HI_ADD || op[7:4] == HI_ADD_CARRY ||
         op[7:4] == HI_AND || op[7:4] == HI_COMPARE)) begin
      d.valid = 1'b1;
      d.fetch = (op[3:0] < LO_SPLIT) ? CYC_2 : CYC_3;
      d.exec = op[0] ? CYC_4 : CYC_3;
      case (op[7:4])
        HI_ADD: d.kind = K_ADD;
        HI_ADD_CARRY: d.kind = K_ADD_CARRY;
        HI_AND: d.kind = K_AND;
        default: d.kind = K_COMPARE;
      endcase
    end else if ((op[3:0] == LO_EXT || op[3:0] == LO_EXT_IMM) &&
                 (op[7:4] == HI_ADD || op[7:4] == HI_ADD_CARRY ||
                  op[7:4] == HI_AND)) begin
      d.valid = 1'b1;
      d.fetch = CYC_4;
      d.exec = CYC_3;
      case (op[7:4])
        HI_ADD: d.kind = K_ADD;
        HI_ADD_CARRY: d.kind = K_ADD_CARRY;
        default: d.kind = K_AND;
      endcase
    end else begin
      case (op)
        OP_ATOMIC: d = '{1'b1, K_ATOMIC, CYC_1, CYC_1};
        OP_BIT_WRITE: d = '{1'b1, K_BIT_WRITE, CYC_2, CYC_2};
        OP_BIT_REVERSE: d = '{1'b1, K_BIT_REVERSE, CYC_2, CYC_2};
        OP_BIT_BRANCH: d = '{1'b1, K_BIT_BRANCH, CYC_3, CYC_3};
        OP_BIT_BRANCH_IND: d = '{1'b1, K_BIT_BRANCH, CYC_3, CYC_4};
        OP_CALL_PAIR: d = '{1'b1, K_CALL, CYC_2, CYC_6};
        OP_CALL_DIRECT: d = '{1'b1, K_CALL, CYC_3, CYC_3};
        OP_CARRY_FLIP: d = '{1'b1, K_CARRY_FLIP, CYC_1, CYC_2};
        OP_CLEAR: d = '{1'b1, K_CLEAR, CYC_2, CYC_2};
        OP_CLEAR_IND: d = '{1'b1, K_CLEAR, CYC_2, CYC_3};
        OP_COMPLEMENT: d = '{1'b1, K_COMPLEMENT, CYC_2, CYC_2};
        OP_COMPLEMENT_IND: d = '{1'b1, K_COMPLEMENT, CYC_2, CYC_3};
        default: d = '0;
      endcase
    end
    // Prefix only legal in front of a compare; it costs one fetch
    // prefix extra fetch
    if (pre) begin
      if (d.valid && d.kind == K_COMPARE) begin
        d.kind = K_COMPARE_CARRY;
        d.fetch = d.fetch + CYC_1;
      end else begin
        d = '0;
      end
    end
    return d;
  endfunction

  // How one flag is treated by one instruction kind
  function automatic mark_t flag_mark(input kind_t k, input int f);
    mark_t m;
    m = MK_KEEP;
    case (k)
      K_ADD, K_ADD_CARRY: m = (f == FLAG_D) ? MK_ZERO : MK_RESULT;
      K_AND, K_COMPLEMENT, K_BIT_WRITE, K_BIT_REVERSE: begin
        if (f == FLAG_Z || f == FLAG_S) m = MK_RESULT;
        else if (f == FLAG_V) m = MK_ZERO;
        else if (f == FLAG_C && k == K_BIT_REVERSE) m = MK_UNDEF;
        else m = MK_KEEP;
      end
      K_COMPARE, K_COMPARE_CARRY:
        m = (f == FLAG_D || f == FLAG_H) ? MK_KEEP : MK_RESULT;
      K_CARRY_FLIP: m = (f == FLAG_C) ? MK_RESULT : MK_KEEP;
      default: m = MK_KEEP;
    endcase
    return m;
  endfunction

endpackage

// ### cpu_exec_alu.sv
// Combinational byte datapath: arithmetic, logic, bit ops and flag values
module cpu_exec_alu
  import cpu_decode_pkg::*;
(
  input wire kind_t kind,
  input wire logic [7:0] dst,
  input wire logic [7:0] src,
  input wire logic [7:0] bit_ctl,
  input wire logic [5:0] flags_in,
  output logic [7:0] result,
  output logic [5:0] flags_out,
  output logic dst_write,
  output logic bit_match
);

  logic [7:0] b_op;
  logic cin;
  logic [8:0] sum;
  logic [4:0] half;
  logic [2:0] sel;
  logic sub;

  // One adder serves add and compare; compare adds the inverted source
  always_comb begin
    sub = (kind == K_COMPARE || kind == K_COMPARE_CARRY);
    b_op = sub ? ~src : src;
    case (kind)
      K_ADD_CARRY: cin = flags_in[FLAG_C];
      K_COMPARE: cin = 1'b1;
      K_COMPARE_CARRY: cin = ~flags_in[FLAG_C];
      default: cin = 1'b0;
    endcase
    sum = {1'b0, dst} + {1'b0, b_op} + {8'h00, cin};
    half = {1'b0, dst[3:0]} + {1'b0, b_op[3:0]} + {4'h0, cin};
    sel = bit_ctl[BIT_SEL_LSB +: 3];
  end

  // Result byte and flag values per kind
  always_comb begin
    result = dst;
    dst_write = 1'b0;
    case (kind)
      K_ADD, K_ADD_CARRY: begin
        result = sum[7:0];
        dst_write = 1'b1;
      end
      K_COMPARE, K_COMPARE_CARRY: result = sum[7:0];
      K_AND: begin
        result = dst & src;
        dst_write = 1'b1;
      end
      K_COMPLEMENT: begin
        result = ~dst;
        dst_write = 1'b1;
      end
      K_CLEAR: begin
        result = 8'h00;
        dst_write = 1'b1;
      end
      K_BIT_WRITE: begin
        result = dst;
        result[sel] = bit_ctl[BIT_P_POS];
        dst_write = 1'b1;
      end
      K_BIT_REVERSE: begin
        for (int i = 0; i < 8; i++) result[i] = dst[7 - i];
        dst_write = 1'b1;
      end
      default: result = dst;
    endcase
    flags_out = flags_in;
    flags_out[FLAG_Z] = (result == 8'h00);
    flags_out[FLAG_S] = result[7];
    flags_out[FLAG_V] = (dst[7] == b_op[7]) && (sum[7] != dst[7]);
    flags_out[FLAG_D] = 1'b0;
    flags_out[FLAG_H] = half[4];
    // Compare reports a borrow, which is the inverted carry out
    if (kind == K_CARRY_FLIP) flags_out[FLAG_C] = ~flags_in[FLAG_C];
    else flags_out[FLAG_C] = sub ? ~sum[8] : sum[8];
    bit_match = (src[sel] == bit_ctl[BIT_P_POS]);
  end

endmodule // cpu_exec_alu

// ### cpu_instruction_decode_timing.sv
// Instruction decoder with fetch/execute cycle timing and Wishbone registers

// Behaviour
// - Add with carry: dst+src+C into dst; opcodes 12..17 pick pairings.
// - Extended add with carry at 18 and 19, 4 fetch and 3 execute cycles.
// - Add uses 02..07 and 08/09; C Z S V H follow result, D cleared.
// - AND uses 52..57 and 58/59; Z S follow, V cleared, C D H kept.
// - Call: SP minus two, push PC, load target; D4 pair, D6 direct.
// - Per instruction, each flag is computed, zeroed, kept or undefined.
// - Each opcode takes its own fetch count, then its execute count.
module cpu_instruction_decode_timing
  import cpu_decode_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic stk_we,
  output logic [15:0] stk_addr,
  output logic [15:0] stk_data,
  output logic done
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [3:0] cnt;
    dec_t dec;
    logic illegal;
    logic [31:0] instr;
    logic [15:0] opnd;
    logic [5:0] flags;
    logic [7:0] result;
    logic [15:0] sp;
    logic [15:0] pc;
    logic ack;
    logic [31:0] rdata;
    logic stk_we;
    logic [15:0] stk_addr;
    logic [15:0] stk_data;
    logic done;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic [7:0] alu_result;
  logic [5:0] alu_flags;
  logic alu_dst_write;
  logic alu_bit_match;
  logic bus_req;
  logic busy;
  logic [31:0] wr_word;
  dec_t start_dec;

  // Byte-lane merge of a Wishbone write into an existing word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wr,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) m[8*i +: 8] = wr[8*i +: 8];
    end
    return m;
  endfunction

  // ****************************************
  // Datapath
  // ****************************************
  cpu_exec_alu u_alu (
    .kind(s_reg.dec.kind),
    .dst(s_reg.opnd[7:0]),
    .src(s_reg.opnd[15:8]),
    .bit_ctl(s_reg.instr[15:8]),
    .flags_in(s_reg.flags),
    .result(alu_result),
    .flags_out(alu_flags),
    .dst_write(alu_dst_write),
    .bit_match(alu_bit_match)
  );

  // Bus request detection and decode of the staged opcode bytes
  always_comb begin
    bus_req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    busy = (s_reg.phase != ST_IDLE);
    start_dec = decode(s_reg.instr[7:0], s_reg.instr[15:8]);
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.stk_we = 1'b0;
    s_next.done = 1'b0;
    s_next.ack = 1'b0;
    wr_word = '0;

    // Sequencer: fetch phase then execute phase
    case (s_reg.phase)
      ST_IDLE: s_next.cnt = '0;
      ST_FETCH: begin
        if (s_reg.cnt == s_reg.dec.fetch - CYC_1) begin
          s_next.phase = ST_EXEC;
          s_next.cnt = '0;
        end else begin
          s_next.cnt = s_reg.cnt + CYC_1;
        end
      end
      ST_EXEC: begin
        if (s_reg.cnt == s_reg.dec.exec - CYC_1) begin
          s_next.phase = ST_IDLE;
          s_next.cnt = '0;
          s_next.done = 1'b1;
          if (alu_dst_write) s_next.result = alu_result;
          else s_next.result = s_reg.opnd[7:0];
          for (int f = 0; f < NUM_FLAGS; f++) begin
            case (flag_mark(s_reg.dec.kind, f))
              MK_RESULT: s_next.flags[f] = alu_flags[f];
              MK_ZERO: s_next.flags[f] = 1'b0;
              default: s_next.flags[f] = s_reg.flags[f];
            endcase
          end
          if (s_reg.dec.kind == K_CALL) begin
            s_next.sp = s_reg.sp - CALL_SP_STEP;
            s_next.stk_we = 1'b1;
            s_next.stk_addr = s_reg.sp - CALL_SP_STEP;
            s_next.stk_data = s_reg.pc;
            s_next.pc = s_reg.opnd;
          end
          // Taken bit branch adds the signed displacement
          if (s_reg.dec.kind == K_BIT_BRANCH && alu_bit_match) begin
            s_next.pc = s_reg.pc +
                        {{8{s_reg.instr[23]}}, s_reg.instr[23:16]};
          end
        end else begin
          s_next.cnt = s_reg.cnt + CYC_1;
        end
      end
      default: begin
        s_next.phase = ST_IDLE;
        s_next.cnt = '0;
      end
    endcase

    // Wishbone slave: one wait state, ack for every address
    if (bus_req) begin
      s_next.ack = 1'b1;
      s_next.rdata = '0;
      if (wb_we_i) begin
        // Configuration writes while busy are dropped
        case (wb_adr_i)
          REG_CTRL: begin
            wr_word = merge('0, wb_dat_i, wb_sel_i);
            if (!busy && wr_word[CTRL_START]) begin
              s_next.dec = start_dec;
              s_next.illegal = ~start_dec.valid;
              s_next.cnt = '0;
              if (start_dec.valid) s_next.phase = ST_FETCH;
            end
          end
          REG_INSTR: begin
            if (!busy) s_next.instr = merge(s_reg.instr, wb_dat_i, wb_sel_i);
          end
          REG_OPERAND: begin
            wr_word = merge({16'h0000, s_reg.opnd}, wb_dat_i, wb_sel_i);
            if (!busy) s_next.opnd = wr_word[15:0];
          end
          REG_FLAGS: begin
            wr_word = merge({24'h000000, s_reg.flags, 2'b00},
                            wb_dat_i, wb_sel_i);
            if (!busy) s_next.flags = wr_word[FLAGS_LSB +: NUM_FLAGS];
          end
          REG_SP: begin
            wr_word = merge({16'h0000, s_reg.sp}, wb_dat_i, wb_sel_i);
            if (!busy) s_next.sp = wr_word[15:0];
          end
          REG_PC: begin
            wr_word = merge({16'h0000, s_reg.pc}, wb_dat_i, wb_sel_i);
            if (!busy) s_next.pc = wr_word[15:0];
          end
          default: wr_word = '0;
        endcase
      end else begin
        // Read mux; unmapped addresses read zero
        case (wb_adr_i)
          REG_CTRL: s_next.rdata[CTRL_START] = busy;
          REG_INSTR: s_next.rdata = s_reg.instr;
          REG_OPERAND: s_next.rdata[15:0] = s_reg.opnd;
          REG_FLAGS: s_next.rdata[FLAGS_LSB +: NUM_FLAGS] = s_reg.flags;
          REG_RESULT: s_next.rdata[7:0] = s_reg.result;
          REG_STATUS: begin
            s_next.rdata[STATUS_BUSY] = busy;
            s_next.rdata[STATUS_ILLEGAL] = s_reg.illegal;
            s_next.rdata[STATUS_FETCH_LSB +: 4] = s_reg.dec.fetch;
            s_next.rdata[STATUS_EXEC_LSB +: 4] = s_reg.dec.exec;
          end
          REG_SP: s_next.rdata[15:0] = s_reg.sp;
          REG_PC: s_next.rdata[15:0] = s_reg.pc;
          default: s_next.rdata = '0;
        endcase
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // All-zero reset matches FLAGS_RST, SP_RST and PC_RST
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o = s_reg.rdata;
  assign wb_ack_o = s_reg.ack;
  assign stk_we = s_reg.stk_we;
  assign stk_addr = s_reg.stk_addr;
  assign stk_data = s_reg.stk_data;
  assign done = s_reg.done;

endmodule // cpu_instruction_decode_timing

// ### cpu_decode_checker_asserts.sv
// Checker of bus handshake, run timing and stack push at the decoder ports
module cpu_decode_checker
  import cpu_decode_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic stk_we,
  input wire logic [15:0] stk_addr,
  input wire logic [15:0] stk_data,
  input wire logic done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] since_reg;
  logic start_w;
  // ********
  // Cycles since the last start write
  // ********
  // Saturates so an illegal start never wraps into a false window
  assign start_w = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
    wb_adr_i == REG_CTRL && wb_dat_i[CTRL_START];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_reg <= 4'h0;
    end else if (start_w) begin
      since_reg <= 4'h1;
    end else if (since_reg != 4'h0 && since_reg != 4'hF) begin
      since_reg <= since_reg + 4'h1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ********
  // Properties
  // ********
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_unmapped_zero;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i > REG_PC
      |=> wb_dat_o == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("bad read");
  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done long");
  property p_done_window;
    done |-> since_reg >= 4'h3 && since_reg <= 4'h9;
  endproperty
  a_done_window: assert property (p_done_window)
    else $error("done time");
  property p_stk_with_done;
    stk_we |-> done ##1 (!stk_we && !done);
  endproperty
  a_stk_with_done: assert property (p_stk_with_done)
    else $error("push");
  property p_stk_hold;
    !stk_we |-> $stable(stk_addr) && $stable(stk_data);
  endproperty
  a_stk_hold: assert property (p_stk_hold) else $error("stack moved");
  property p_stk_call_time;
    stk_we |-> since_reg == 4'h7 || since_reg == 4'h9;
  endproperty
  a_stk_call_time: assert property (p_stk_call_time)
    else $error("push time");
  c_done: cover property (done);
  c_push: cover property (stk_we);
  c_start: cover property (start_w ##1 wb_ack_o);
endmodule // cpu_decode_checker

bind cpu_instruction_decode_timing cpu_decode_checker chk_u (.clk(clk),
  .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .stk_we(stk_we), .stk_addr(stk_addr),
  .stk_data(stk_data), .done(done));

// ### call_stack_model.sv
// Stack memory model that keeps the last word a call pushed
module call_stack_model (
  input wire logic clk,
  input wire logic stk_we,
  input wire logic [15:0] stk_addr,
  input wire logic [15:0] stk_data,
  output logic [15:0] top_word,
  output logic [15:0] top_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    top_word = 16'h0000;
    top_addr = 16'h0000;
  end
  // store return address
  // Only the newest push is kept; deeper frames are not needed here
  always @(posedge clk) begin
    if (stk_we === 1'b1) begin
      top_addr <= stk_addr;
      top_word <= stk_data;
    end
  end
endmodule // call_stack_model

// ### tb.sv
// Bench: opcode sweep, calls, illegal codes and resets against a model
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_decode_pkg::*;
  logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, stk_we, done;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] stk_addr, stk_data, top_word, top_addr;
  int err_total, total_checks, cyc_cnt, seed, k, d, s, fl, res, nfl;
  int sp, pc, t;
  int his[4] = '{0, 1, 5, 10};
  int oth[10] = '{16'h2F11, 16'hE222, 16'hD522, 16'hF633, 16'hF734,
                  16'hEF12, 16'hB022, 16'hB123, 16'h6022, 16'h6123};
  // ********
  // Design, partner, clock and hang guard
  // ********
  cpu_instruction_decode_timing dut_u (.clk(clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stk_we(stk_we),
    .stk_addr(stk_addr), .stk_data(stk_data), .done(done));
  call_stack_model stack_u (.clk(clk), .stk_we(stk_we), .stk_addr(stk_addr),
    .stk_data(stk_data), .top_word(top_word), .top_addr(top_addr));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  // ********
  // Tasks
  // ********
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Classic cycle held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  function automatic int zs(input int r);
    return ((r & 255) == 0 ? 16 : 0) | ((r & 128) >> 4);
  endfunction
  // Bit order reversal of one byte
  function automatic int rev8(input int v);
    int r;
    r = 0;
    for (int j = 0; j < 8; j++) begin
      if (v & (1 << j)) r |= 128 >> j;
    end
    return r;
  endfunction
  // Start, optionally poke FLAGS while busy, then time the run to done
  task automatic run(input int b0, input int b1, input int ef, input int ee,
                     input int junk);
    wb(1'b1, REG_INSTR, (b1 << 8) | b0);
    wb(1'b1, REG_CTRL, 32'h1);
    k = 1;
    if (junk) begin
      wb(1'b1, REG_FLAGS, $random(seed));
      k = 4;
    end
    do begin
      @(posedge clk);
      k++;
    end while (done !== 1'b1 && k < 30);
    // Edges after the start edge up to the one that samples done
    check("cycles", ef + ee + 1, k);
    wb(1'b0, REG_STATUS, 32'h0);
    check("status", (ee << 6) | (ef << 2), rd & 32'h3FF);
  endtask
  // Add, add with carry, AND and compare against an integer model
  task automatic alu(input int hi, input int lo, input int pre);
    int c, r, ef;
    d = $random(seed) & 255;
    s = $random(seed) & 255;
    fl = $random(seed) & 63;
    c = (hi == 1 || pre) ? fl >> 5 : 0;
    if (hi == 5) begin
      res = d & s;
      nfl = (fl & 8'h23) | zs(res);
    end else if (hi == 10) begin
      r = d - s - c;
      res = d;
      nfl = (r < 0 ? 32 : 0) | zs(r) | (((d ^ s) & (d ^ r) & 128) >> 5)
        | (fl & 3);
    end else begin
      r = d + s + c;
      res = r & 255;
      nfl = (r > 255 ? 32 : 0) | zs(r) | ((~(d ^ s) & (d ^ r) & 128) >> 5)
        | ((d & 15) + (s & 15) + c > 15 ? 1 : 0);
    end
    ef = ((lo > 7) ? 4 : (lo < 4 ? 2 : 3)) + pre;
    wb(1'b1, REG_FLAGS, fl << 2);
    wb(1'b1, REG_OPERAND, (s << 8) | d);
    run(pre ? 8'h1F : hi * 16 + lo, pre ? hi * 16 + lo : 0, ef,
        lo > 7 ? 3 : 3 + (lo & 1), 1);
    wb(1'b0, REG_RESULT, 32'h0);
    check("result", res, rd);
    wb(1'b0, REG_FLAGS, 32'h0);
    check("flags", nfl << 2, rd);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ********
  // Main sequence
  // ********
  initial begin
    seed = 32'h9B14;
    err_total = 0;
    total_checks = 0;
    cyc_cnt = 0;
    rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    for (int a = 0; a <= 32; a += 4) begin
      wb(1'b0, 8'(a), 32'h0);
      check("reset value", 32'h0, rd);
    end
    $display("test reset done");
    foreach (his[i]) begin
      for (int lo = 2; lo < 10; lo++) begin
        if (his[i] != 10 || lo < 8) begin
          alu(his[i], lo, 0);
        end
      end
    end
    for (int lo = 2; lo < 8; lo++) begin
      alu(10, lo, 1);
    end
    $display("test alu done");
    pc = 0;
    foreach (oth[i]) begin
      d = $random(seed) & 255;
      s = $random(seed) & 255;
      t = $random(seed) & 16'hFFFF;
      fl = $random(seed) & 63;
      wb(1'b1, REG_FLAGS, fl << 2);
      wb(1'b1, REG_OPERAND, (s << 8) | d);
      // Low byte of t is the p/bit byte, high byte the displacement
      run(oth[i] >> 8, t, (oth[i] >> 4) & 15, oth[i] & 15, 0);
      k = (t >> 4) & 7;
      res = d;
      nfl = fl;
      case (oth[i] >> 8)
        8'hEF: nfl = fl ^ 32;
        8'hE2: res = (t & 128) ? d | (1 << k) : d & ~(1 << k);
        8'hD5: res = rev8(d);
        8'h60, 8'h61: res = ~d & 255;
        8'hB0, 8'hB1: res = 0;
        8'hF6, 8'hF7: begin
          if (((s >> k) & 1) == ((t >> 7) & 1)) begin
            pc = (pc + ((t >> 8) ^ 128) - 128) & 16'hFFFF;
          end
        end
        default: nfl = fl;
      endcase
      // Bit write, bit reverse and complement: Z S follow, V zero
      if ((oth[i] >> 8) inside {8'hE2, 8'hD5, 8'h60, 8'h61}) begin
        nfl = (fl & 8'h23) | zs(res);
      end
      wb(1'b0, REG_FLAGS, 32'h0);
      check("flags", nfl << 2, rd);
      wb(1'b0, REG_RESULT, 32'h0);
      check("result", res, rd);
      wb(1'b0, REG_PC, 32'h0);
      check("pc", pc, rd);
    end
    $display("test other done");
    sp = 1;
    pc = 16'h1234;
    wb(1'b1, REG_SP, sp);
    wb(1'b1, REG_PC, pc);
    for (int i = 0; i < 2; i++) begin
      t = $random(seed) & 16'hFFFF;
      sp = (sp - 2) & 16'hFFFF;
      wb(1'b1, REG_OPERAND, t);
      run(i ? 8'hD6 : 8'hD4, 0, i ? 3 : 2, i ? 3 : 6, 0);
      check("stack addr", sp, top_addr);
      check("stack word", pc, top_word);
      wb(1'b0, REG_SP, 32'h0);
      check("sp", sp, rd);
      wb(1'b0, REG_PC, 32'h0);
      check("pc", t, rd);
      pc = t;
    end
    $display("test call done");
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, REG_INSTR, i ? 8'hA8 : 16'h021F);
      wb(1'b1, REG_CTRL, 32'h1);
      k = 0;
      repeat (12) begin
        @(posedge clk);
        k += (done !== 1'b0);
      end
      check("done count", 0, k);
      wb(1'b0, REG_STATUS, 32'h0);
      check("illegal", 2, rd & 32'h3);
    end
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, REG_SP, 32'h0);
    check("sp after reset", 32'h0, rd);
    $display("test illegal and reset done");
    print_verdict();
  end
endmodule // tb
